/* logic/adts_conv_if.sv */
// trigger requests, grants and conversion events between the sub-blocks
// assumes all members run on pclk
`timescale 1ns/10ps
`default_nettype none
interface adts_conv_if;
  logic [21:0] level_sel;   // 1 = level-sensitive
  logic [21:0] req;         // pending conversion requests
  logic [21:0] grant;       // one-hot, one cycle
  logic        ovr;         // edge lost while one still pending
  logic        early;       // early interrupt pulse
  logic        done;        // data ready pulse
  logic [4:0]  chan;        // channel in conversion
  logic        busy;

  modport trig (input level_sel, grant, output req, ovr);
  modport seq  (input req, output grant, early, done, chan, busy);
  modport top  (output level_sel, input req, grant, ovr, early, done,
                chan, busy);
endinterface : adts_conv_if
`default_nettype wire

/* logic/adts_core_seq.sv */
// core clock divider and conversion sequencer with early interrupt
// assumes requests come from adts_trig_sense on the same clock
`timescale 1ns/10ps
`default_nettype none
module adts_core_seq (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] lead,
  input  wire logic [1:0] res,
  input  wire logic [6:0] div,
  adts_conv_if.seq        cif
);

  typedef enum logic {ADTS_IDLE, ADTS_CONV} adts_state_e;

  adts_state_e state_reg, state_next;
  logic [7:0]  dcnt_reg, dcnt_next, period;
  logic        tick;
  logic [4:0]  rem_reg, rem_next, len, lead_ck;
  logic [4:0]  chan_reg, chan_next;
  logic [21:0] grant_reg, grant_next;
  logic        early_reg, early_next, done_reg, done_next;

  // one core clock = 2*div source clocks, zero treated as one
  assign period = {(div == 7'h00) ? 7'h01 : div, 1'b0};
  assign tick   = (dcnt_reg == period - 8'h01);

  // invalid lead codes above four saturate
  assign lead_ck = 5'(((lead > adts_pkg::LEAD_MAX) ? adts_pkg::LEAD_MAX
                                                   : lead)) + 5'h02;

  always_comb begin
    unique case (res)
      2'h0: len = adts_pkg::CONV_LEN_6;
      2'h1: len = adts_pkg::CONV_LEN_8;
      2'h2: len = adts_pkg::CONV_LEN_10;
      2'h3: len = adts_pkg::CONV_LEN_12;
    endcase
  end

  always_comb begin
    dcnt_next  = tick ? 8'h00 : dcnt_reg + 8'h01;
    state_next = state_reg;
    rem_next   = rem_reg;
    chan_next  = chan_reg;
    grant_next = '0;
    early_next = 1'b0;
    done_next  = 1'b0;
    unique case (state_reg)
      ADTS_IDLE: begin
        // lowest channel wins; a grant is never issued twice in a row
        if (|cif.req && grant_reg == '0) begin
          for (int i = 21; i >= 0; i--) begin
            if (cif.req[i]) begin
              chan_next = 5'(i);
            end
          end
          grant_next[chan_next] = 1'b1;
          rem_next   = len;
          state_next = ADTS_CONV;
        end
      end
      ADTS_CONV: begin
        if (tick) begin
          rem_next = rem_reg - 5'h01;
          if (rem_reg == lead_ck)
            early_next = 1'b1;                          // RQ7
          if (rem_reg == 5'h01) begin
            done_next  = 1'b1;
            state_next = ADTS_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ADTS_IDLE;
      dcnt_reg  <= 8'h00;
      rem_reg   <= 5'h00;
      chan_reg  <= 5'h00;
      grant_reg <= '0;
      early_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      dcnt_reg  <= dcnt_next;
      rem_reg   <= rem_next;
      chan_reg  <= chan_next;
      grant_reg <= grant_next;
      early_reg <= early_next;
      done_reg  <= done_next;
    end
  end

  assign cif.grant = grant_reg;
  assign cif.early = early_reg;
  assign cif.done  = done_reg;
  assign cif.chan  = chan_reg;
  assign cif.busy  = (state_reg == ADTS_CONV);

  // early pulse fires exactly lead+1 core ticks before done
  logic [4:0] ticks_since_early;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ticks_since_early <= 5'h00;
    else if (early_reg)
      ticks_since_early <= 5'h00;
    else if (tick)
      ticks_since_early <= ticks_since_early + 5'h01;
  end

  // counter clears one cycle after the early tick, then sees lead+1 ticks
  a_early_lead: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    done_reg && $stable(lead) && $stable(div) |->
      ticks_since_early == lead_ck - 5'h01)
    else $error("early interrupt lead time wrong");

  a_one_grant: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(grant_reg))
    else $error("more than one grant");

endmodule : adts_core_seq
`default_nettype wire

/* logic/adts_pkg.sv */
// shared constants for the trigger-sense and core-timing block
// assumes a 32-bit apb slave on pclk, one converter core sequencer
package adts_pkg;

  localparam int unsigned NCH       = 22;
  localparam int unsigned CHW       = 5;
  localparam int unsigned NLOW      = 16;
  localparam int unsigned NHIGH     = 6;

  // register byte offsets
  localparam logic [11:0] OFS_CORE_CTL   = 12'h000;
  localparam logic [11:0] OFS_SENSE_LOW  = 12'h004;
  localparam logic [11:0] OFS_SENSE_HIGH = 12'h008;
  localparam logic [11:0] OFS_ESTAT_LOW  = 12'h00c;
  localparam logic [11:0] OFS_ESTAT_HIGH = 12'h010;
  localparam logic [11:0] OFS_EVT_STAT   = 12'h014;
  localparam logic [11:0] OFS_EVT_MASK   = 12'h018;

  // core control high fields
  localparam int unsigned LEAD_LSB  = 10;
  localparam int unsigned LEAD_W    = 3;
  localparam int unsigned RES_LSB   = 8;
  localparam int unsigned RES_W     = 2;
  localparam int unsigned DIV_LSB   = 0;
  localparam int unsigned DIV_W     = 7;
  localparam logic [2:0]  LEAD_RST  = 3'h0;
  localparam logic [1:0]  RES_RST   = 2'h3;
  localparam logic [6:0]  DIV_RST   = 7'h00;
  localparam logic [2:0]  LEAD_MAX  = 3'h4;

  localparam logic [15:0] SENSE_LOW_RST  = 16'h0000;
  localparam logic [5:0]  SENSE_HIGH_RST = 6'h00;

  // event status / mask bits
  localparam int unsigned EVT_W     = 3;
  localparam int unsigned EVT_EARLY = 0;
  localparam int unsigned EVT_DONE  = 1;
  localparam int unsigned EVT_OVR   = 2;
  localparam logic [2:0]  EVT_RST   = 3'h0;

  // conversion length in core clocks per resolution code (6/8/10/12 bit)
  localparam logic [4:0]  CONV_LEN_6  = 5'h08;
  localparam logic [4:0]  CONV_LEN_8  = 5'h0a;
  localparam logic [4:0]  CONV_LEN_10 = 5'h0c;
  localparam logic [4:0]  CONV_LEN_12 = 5'h0e;

endpackage : adts_pkg

/* logic/adts_top.sv */
// trigger-sense select, core timing control and early interrupt status
// assumes an apb master on pclk and async trigger pins
//
// Operation
// RQ1 - channels 0..15 level select live in low sense register, bit = channel
// RQ2 - channels 16..21 level select in high sense register bits 5..0
// RQ3 - a set select bit makes that channel's trigger level-sensitive
// RQ4 - a clear bit means edge-sensitive; all bits clear after reset
// RQ5 - high sense bits 15..6 read zero and ignore writes
// RQ6 - software avoids lead-time codes invalid at the lowest resolution
// RQ7 - early interrupt comes lead+1 core clocks before data ready
// RQ8 - early status stays clear until generated; result read re-arms it
`timescale 1ns/10ps
`default_nettype none
module adts_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [21:0] trig_in,
  input  wire logic [21:0] result_read,
  output logic             irq,
  output logic             early_irq,
  output logic             data_ready,
  output logic      [4:0]  data_chan
);

  adts_conv_if cif ();

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [2:0]  lead_reg, lead_next;
  logic [1:0]  res_reg, res_next;
  logic [6:0]  div_reg, div_next;
  logic [15:0] sense_lo_reg, sense_lo_next;
  logic [5:0]  sense_hi_reg, sense_hi_next;
  logic [21:0] estat_reg, estat_next;
  logic [2:0]  evt_reg, evt_next, mask_reg, mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        irq_reg, irq_next;
  logic        early_out_reg, done_out_reg;
  logic [4:0]  chan_out_reg;
  logic        wr_en, acc, mapped;
  logic [21:0] early_set;
  logic [2:0]  evt_set;

  assign cif.level_sel = {sense_hi_reg, sense_lo_reg};  // RQ1

  ////////////////////////////////////////////////////////////////////////
  // sub-blocks

  adts_trig_sense u_trig (
    .pclk    (pclk),
    .presetn (presetn),
    .trig_in (trig_in),
    .cif     (cif.trig)
  );

  adts_core_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .lead    (lead_reg),
    .res     (res_reg),
    .div     (div_reg),
    .cif     (cif.seq)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb: one wait state so pready and prdata both come from flops

  assign acc    = psel && penable;
  assign wr_en  = acc && pready_reg && pwrite;
  assign mapped = (paddr == adts_pkg::OFS_CORE_CTL)   ||
                  (paddr == adts_pkg::OFS_SENSE_LOW)  ||
                  (paddr == adts_pkg::OFS_SENSE_HIGH) ||
                  (paddr == adts_pkg::OFS_ESTAT_LOW)  ||
                  (paddr == adts_pkg::OFS_ESTAT_HIGH) ||
                  (paddr == adts_pkg::OFS_EVT_STAT)   ||
                  (paddr == adts_pkg::OFS_EVT_MASK);

  // read mux; unimplemented bits are plain zero fill
  always_comb begin
    pready_next  = acc && !pready_reg;
    pslverr_next = acc && !pready_reg && !mapped;
    prdata_next  = 32'h0000_0000;
    if (acc && !pready_reg && !pwrite) begin
      unique case (paddr)
        adts_pkg::OFS_CORE_CTL:
          prdata_next = {19'h0, lead_reg, res_reg, 1'b0, div_reg};
        adts_pkg::OFS_SENSE_LOW:
          prdata_next = {16'h0, sense_lo_reg};             // RQ1
        adts_pkg::OFS_SENSE_HIGH:
          prdata_next = {26'h0, sense_hi_reg};             // RQ5
        adts_pkg::OFS_ESTAT_LOW:
          prdata_next = {16'h0, estat_reg[15:0]};
        adts_pkg::OFS_ESTAT_HIGH:
          prdata_next = {26'h0, estat_reg[21:16]};
        adts_pkg::OFS_EVT_STAT:
          prdata_next = {29'h0, evt_reg};
        adts_pkg::OFS_EVT_MASK:
          prdata_next = {29'h0, mask_reg};
        default:
          prdata_next = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration writes

  always_comb begin
    lead_next     = lead_reg;
    res_next      = res_reg;
    div_next      = div_reg;
    sense_lo_next = sense_lo_reg;
    sense_hi_next = sense_hi_reg;
    mask_next     = mask_reg;
    if (wr_en) begin
      unique case (paddr)
        adts_pkg::OFS_CORE_CTL: begin
          // lead codes are stored as written; invalid ones saturate later
          lead_next = pwdata[adts_pkg::LEAD_LSB +: adts_pkg::LEAD_W];
          res_next  = pwdata[adts_pkg::RES_LSB +: adts_pkg::RES_W];
          div_next  = pwdata[adts_pkg::DIV_LSB +: adts_pkg::DIV_W];
        end
        adts_pkg::OFS_SENSE_LOW:
          sense_lo_next = pwdata[15:0];                    // RQ1
        adts_pkg::OFS_SENSE_HIGH:
          sense_hi_next = pwdata[5:0];                     // RQ2
        adts_pkg::OFS_EVT_MASK:
          mask_next = pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // early status and sticky events, set wins over clear

  always_comb begin
    early_set = '0;
    if (cif.early)
      early_set[cif.chan] = 1'b1;
    // a buffer read re-arms; a same-cycle early event still lands
    estat_next = (estat_reg & ~result_read) | early_set;   // RQ8
    evt_set = '0;
    evt_set[adts_pkg::EVT_EARLY] = cif.early;
    evt_set[adts_pkg::EVT_DONE]  = cif.done;
    evt_set[adts_pkg::EVT_OVR]   = cif.ovr;
    evt_next = evt_reg;
    if (wr_en && paddr == adts_pkg::OFS_EVT_STAT)
      evt_next = evt_reg & ~pwdata[2:0];
    evt_next = evt_next | evt_set;
    irq_next = |(evt_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_reg      <= adts_pkg::LEAD_RST;
      res_reg       <= adts_pkg::RES_RST;
      div_reg       <= adts_pkg::DIV_RST;
      sense_lo_reg  <= adts_pkg::SENSE_LOW_RST;            // RQ4
      sense_hi_reg  <= adts_pkg::SENSE_HIGH_RST;           // RQ4
      estat_reg     <= '0;
      evt_reg       <= adts_pkg::EVT_RST;
      mask_reg      <= adts_pkg::EVT_RST;
      prdata_reg    <= 32'h0000_0000;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      irq_reg       <= 1'b0;
      early_out_reg <= 1'b0;
      done_out_reg  <= 1'b0;
      chan_out_reg  <= 5'h00;
    end else begin
      lead_reg      <= lead_next;
      res_reg       <= res_next;
      div_reg       <= div_next;
      sense_lo_reg  <= sense_lo_next;
      sense_hi_reg  <= sense_hi_next;
      estat_reg     <= estat_next;
      evt_reg       <= evt_next;
      mask_reg      <= mask_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
      irq_reg       <= irq_next;
      early_out_reg <= cif.early;
      done_out_reg  <= cif.done;
      chan_out_reg  <= cif.chan;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign irq        = irq_reg;
  assign early_irq  = early_out_reg;
  assign data_ready = done_out_reg;
  assign data_chan  = chan_out_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_low_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    wr_en && paddr == adts_pkg::OFS_SENSE_LOW |=>
      cif.level_sel[15:0] == $past(pwdata[15:0]))
    else $error("low sense write not applied");

  a_high_write: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    wr_en && paddr == adts_pkg::OFS_SENSE_HIGH |=>
      cif.level_sel[21:16] == $past(pwdata[5:0]))
    else $error("high sense write not applied");

  a_high_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    pready && $past(acc && !pwrite && paddr == adts_pkg::OFS_SENSE_HIGH)
      |-> prdata[31:6] == 26'h0)
    else $error("high sense upper bits not zero");

  a_sense_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    !(wr_en && (paddr == adts_pkg::OFS_SENSE_LOW ||
                paddr == adts_pkg::OFS_SENSE_HIGH))
      |=> $stable(cif.level_sel))
    else $error("sense bits changed without a write");

  a_estat_set: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    cif.early |=> estat_reg[$past(cif.chan)])
    else $error("early status not set");

  a_estat_rise: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    !cif.early |=> (estat_reg & ~$past(estat_reg)) == 22'h0)
    else $error("early status set without event");

  // channel 3 is the one whose result buffer the edge scenario reads
  a_estat_rearm: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    result_read[3] && !(cif.early && cif.chan == 5'h03)
      |=> !estat_reg[3])
    else $error("result read did not re-arm status");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(evt_next) & $past(mask_next)))
    else $error("irq does not follow masked status");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pready |=> pready)
    else $error("apb access not answered");

endmodule : adts_top
`default_nettype wire

/* logic/adts_trig_sense.sv */
// per-channel trigger synchroniser and edge/level request logic
// assumes trigger pins are asynchronous to pclk
`timescale 1ns/10ps
`default_nettype none
module adts_trig_sense (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [21:0] trig_in,
  adts_conv_if.trig        cif
);

  logic [21:0] s1_reg, s2_reg, s3_reg, pend_reg, pend_next;
  logic [21:0] rise;
  logic        ovr_reg, ovr_next;

  // two-stage sync, third stage only feeds the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= trig_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign rise = s2_reg & ~s3_reg;

  genvar g;
  generate
    for (g = 0; g < 22; g++) begin : g_ch
      // edge: latch until granted, a new edge beats the grant
      always_comb begin
        pend_next[g] = pend_reg[g];
        if (cif.grant[g] || cif.level_sel[g])
          pend_next[g] = 1'b0;
        if (rise[g] && !cif.level_sel[g])
          pend_next[g] = 1'b1;                              // RQ4
      end
      // level: request stands while the synced input is high
      assign cif.req[g] = cif.level_sel[g] ? s2_reg[g]     // RQ3
                                           : pend_reg[g];   // RQ4
    end
  endgenerate

  // overrun: an edge arriving while the previous one is still waiting
  always_comb begin
    ovr_next = |(rise & pend_reg & ~cif.grant & ~cif.level_sel);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= '0;
      ovr_reg  <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      ovr_reg  <= ovr_next;
    end
  end

  assign cif.ovr = ovr_reg;

  a_edge_pend: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    rise[0] && !cif.level_sel[0] |=> pend_reg[0])
    else $error("edge on channel 0 not latched");

  // channel 17 is the one the level scenario exercises
  a_level_req: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    cif.level_sel[17] |-> cif.req[17] == s2_reg[17])
    else $error("level request does not follow input");

endmodule : adts_trig_sense
`default_nettype wire

/* tb/adts_trig_src.sv */
// trigger source model: pwm or timer outputs feeding the trigger pins
// assumes the bench calls its tasks from a process clocked by pclk
`timescale 1ns/10ps
`default_nettype none
module adts_trig_src (
  input  wire logic        pclk,
  output logic      [21:0] trig_in
);
  initial trig_in = 22'h000000;

  // level change lands just after an edge, as a registered source would
  task automatic drive(input int ch, input logic v);
    @(posedge pclk);
    trig_in[ch] <= v;
  endtask : drive

  // short rising pulse, long enough to pass the two-flop synchroniser
  task automatic pulse(input int ch);
    drive(ch, 1'b1);
    repeat (4) @(posedge pclk);
    trig_in[ch] <= 1'b0;
  endtask : pulse
endmodule : adts_trig_src
`default_nettype wire

/* tb/test_adts_top.sv */
// self-checking bench for the trigger-sense and core-timing block
// assumes a 125 MHz pclk and the one-wait-state apb slave of the design
`timescale 1ns/10ps
`default_nettype none
module test_adts_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [21:0] trig_in;
  logic [21:0] result_read;
  logic        irq;
  logic        early_irq;
  logic        data_ready;
  logic [4:0]  data_chan;
  int          error_cnt;
  int          n_checks;
  logic [31:0] rd;
  logic        er;
  int          gap;
  logic [4:0]  ch;

  adts_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .result_read(result_read), .irq(irq),
    .early_irq(early_irq), .data_ready(data_ready),
    .data_chan(data_chan));
  adts_trig_src src_u (.pclk(pclk), .trig_in(trig_in));

  always #4 pclk = ~pclk;

  //////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic hang(input string m);
    error_cnt++;
    $display("[FAIL] %0t timeout %s", $time, m);
    final_report();
  endtask : hang

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang("apb");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // waits for data ready; gap is edges since the early pulse
  task automatic wait_done;
    int i;
    int te;
    te = -1000;
    for (i = 0; i < 400; i++) begin
      @(posedge pclk);
      if (early_irq === 1'b1) te = i;
      if (data_ready === 1'b1) break;
    end
    if (i == 400) hang("conversion");
    gap = i - te;
    ch = data_chan;
  endtask : wait_done

  //////////////////////////////////////////////////////////////////////
  // reset values and sense register layout, unmapped access refused
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h00000300, "ctl rst");
    apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h0, "low rst");
    apb(1'b0, 12'h008, 32'h0); chk(rd, 32'h0, "high rst");
    apb(1'b0, 12'h00c, 32'h0); chk(rd, 32'h0, "estat rst");
    apb(1'b1, 12'h004, 32'hffffa5c3);
    apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h0000a5c3, "low rw");
    apb(1'b1, 12'h008, 32'hffffffff);
    apb(1'b0, 12'h008, 32'h0); chk(rd, 32'h0000003f, "high rw");
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h01c, 32'h1); chk({31'h0, er}, 32'h1, "unmapped err");
    apb(1'b0, 12'h01c, 32'h0); chk(rd, 32'h0, "unmapped rd");
  endtask : t_regs

  // edge mode: a held-high trigger converts once only
  task automatic t_edge;
    int i;
    int n;
    apb(1'b1, 12'h000, 32'h00000001);
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h00000001, "ctl rw");
    apb(1'b1, 12'h018, 32'h00000002);
    src_u.drive(3, 1'b1);
    wait_done(); chk({27'h0, ch}, 32'h3, "edge chan");
    n = 0;
    for (i = 0; i < 120; i++) begin
      @(posedge pclk);
      if (data_ready === 1'b1) n++;
    end
    chk(n, 0, "edge repeat");
    chk({31'h0, irq}, 32'h1, "irq done");
    apb(1'b0, 12'h00c, 32'h0); chk(rd, 32'h8, "estat set");
    @(posedge pclk);
    result_read <= 22'h000008;
    @(posedge pclk);
    result_read <= 22'h000000;
    apb(1'b0, 12'h00c, 32'h0); chk(rd, 32'h0, "estat rearm");
    apb(1'b1, 12'h014, 32'h00000002);
    apb(1'b0, 12'h014, 32'h0); chk(rd, 32'h1, "w1c");
    chk({31'h0, irq}, 32'h0, "irq clear");
    apb(1'b1, 12'h014, 32'h00000007);
    src_u.drive(3, 1'b0);
  endtask : t_edge

  // level mode on channel 17: held trigger keeps converting
  task automatic t_level;
    apb(1'b1, 12'h008, 32'h00000002);
    src_u.drive(17, 1'b1);
    wait_done(); chk({27'h0, ch}, 32'h11, "level chan 1");
    wait_done(); chk({27'h0, ch}, 32'h11, "level chan 2");
    apb(1'b0, 12'h010, 32'h0); chk(rd, 32'h2, "estat high");
    src_u.drive(17, 1'b0);
    repeat (80) @(posedge pclk);
    apb(1'b1, 12'h008, 32'h0);
  endtask : t_level

  // lead time: early pulse comes lead+1 core clocks (2 pclk) ahead
  task automatic t_lead;
    int l;
    for (l = 0; l < 5; l++) begin
      apb(1'b1, 12'h000, (l << 10) | 32'h301);
      src_u.pulse(0);
      wait_done(); chk(gap, 2 * (l + 1), "lead gap");
      repeat (20) @(posedge pclk);
    end
  endtask : t_lead

  //////////////////////////////////////////////////////////////////////
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    result_read = 22'h000000;
    error_cnt   = 0;
    n_checks    = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_edge();
    t_level();
    t_lead();
    final_report();
  end
endmodule : test_adts_top
`default_nettype wire
